/* include/key_scan_pkg.sv */
/*
  Constants, state type and helper functions for the key matrix scanner.
  Assumes a 200 MHz core clock; oscillator periods are counted as ticks.
*/
package key_scan_pkg;

  localparam int KEY_LINES   = 6;
  localparam int SENSE_LINES = 5;
  localparam int KEY_BITS    = 30;

  // Oscillator period figures, in picoseconds
  localparam int CORE_PERIOD_PS  = 5000;
  localparam int OSC_PERIOD_PS   = 2000000;
  localparam int OSC_DIV_DEFAULT = OSC_PERIOD_PS / CORE_PERIOD_PS;
  localparam int OSC_DIV_W       = 16;

  // Scan timing in oscillator periods
  localparam logic [9:0] SCAN_PASS_T = 10'd384;
  localparam logic [9:0] LINE_SLOT_T = 10'd64;
  localparam logic [9:0] SAMPLE_AT_T = 10'd32;
  localparam logic [9:0] REQ_DELAY_T = 10'd800;
  localparam logic [9:0] TWO_PASS_T  = 10'd768;

  // Register port
  localparam int         ADDR_W      = 4;
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_KEYS   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_SLEEP_BIT  = 6;
  localparam int KEYS_ACK_BIT    = 30;
  localparam int STAT_REQ_BIT    = 0;
  localparam int STAT_CFG_BIT    = 1;
  localparam int STAT_LINE_BIT   = 2;
  localparam int STAT_OSC_BIT    = 3;

  localparam logic [5:0]  CFG_RESET   = 6'h00;
  localparam logic        SLEEP_RESET = 1'b0;
  localparam logic [29:0] KEYS_RESET  = 30'h00000000;
  localparam logic [9:0]  CNT_ZERO    = 10'h000;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_IDLE,
    ST_PASS1,
    ST_PASS2,
    ST_DELAY,
    ST_REQ
  } scan_state_t;

  // Position within one pass
  function automatic logic [9:0] passPos(input logic [9:0] cnt);
    passPos = (cnt >= SCAN_PASS_T) ? cnt - SCAN_PASS_T : cnt;
  endfunction : passPos

  // Scan line driven at a given count
  function automatic logic [2:0] lineOf(input logic [9:0] cnt);
    logic [9:0] pos;
    pos    = passPos(cnt);
    lineOf = pos[8:6];
  endfunction : lineOf

  // Offset inside the current line slot
  function automatic logic [5:0] slotOffset(input logic [9:0] cnt);
    logic [9:0] pos;
    pos        = passPos(cnt);
    slotOffset = pos[5:0];
  endfunction : slotOffset

endpackage : key_scan_pkg

/* include/scan_timing_if.sv */
/*
  Oscillator run request and period tick between scanner and tick source.
  Assumes both ends share core_clk.
*/
`timescale 1ns/100ps
interface scan_timing_if;
  logic oscRun;
  logic oscTick;

  modport source (input oscRun, output oscTick);
  modport core   (output oscRun, input oscTick);
endinterface : scan_timing_if

/* rtl/osc_tick_gen.sv */
/*
  Stand-in for the RC oscillator: one tick per oscillator period.
  Assumes core_clk and a synchronised active-low reset.
*/
`timescale 1ns/100ps
module osc_tick_gen
  import key_scan_pkg::*;
#(
  parameter int DIV = OSC_DIV_DEFAULT
) (
  input wire logic      core_clk,
  input wire logic      rstSyncN,
  scan_timing_if.source timing
);

  logic [OSC_DIV_W-1:0] divCnt_reg;
  logic [OSC_DIV_W-1:0] divCnt_next;
  wire                  wrapNow = (divCnt_reg == OSC_DIV_W'(DIV - 1));

  // A stopped oscillator restarts from phase zero
  assign divCnt_next   = (!timing.oscRun || wrapNow) ? '0 : divCnt_reg + 1'b1;
  assign timing.oscTick = timing.oscRun && wrapNow;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_next;
    end
  end

endmodule : osc_tick_gen

/* rtl/pin_sync.sv */
/*
  Two-stage synchroniser bank for pin inputs.
  Assumes inputs are asynchronous to core_clk; outputs reset low.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rstSyncN,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinSync
);

  logic [W-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stage1_reg <= '0;
      pinSync    <= '0;
    end else begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end

endmodule : pin_sync

/* rtl/key_matrix_scanner.sv */
/*
  Key matrix scanner: six scan outputs, five sense inputs, 30-bit key map,
  double-scan debounce and open-drain read request line.
  Assumes a register port on core_clk, pins asynchronous to core_clk,
  and an external pull-up on the request line.
*/
`timescale 1ns/100ps

module key_matrix_scanner
  import key_scan_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEFAULT
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_W-1:0]      regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                   regWrStb,
  input  wire logic                   regRdStb,
  output logic      [31:0]            regRdData,
  output logic      [KEY_LINES-1:0]   scanOutputs,
  input  wire logic [SENSE_LINES-1:0] senseInputs,
  input  wire logic                   xferSelect,
  input  wire logic                   dataOutIn,
  output logic                        dataOutOut,
  output logic                        dataOutOeN
);

  // Reset release
  logic rstPipe1_reg;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe1_reg <= 1'b0;
      rstSyncN     <= 1'b0;
    end else begin
      rstPipe1_reg <= 1'b1;
      rstSyncN     <= rstPipe1_reg;
    end
  end

  // Pin synchronisers
  logic [SENSE_LINES+1:0] pinSyncBus;
  logic [SENSE_LINES-1:0] senseSync;
  logic                   xferSync;
  logic                   lineSync;

  pin_sync #(
    .W (SENSE_LINES + 2)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .pinIn    ({dataOutIn, xferSelect, senseInputs}),
    .pinSync  (pinSyncBus)
  );

  assign senseSync = pinSyncBus[SENSE_LINES-1:0];
  assign xferSync  = pinSyncBus[SENSE_LINES];
  assign lineSync  = pinSyncBus[SENSE_LINES+1];

  // Oscillator ticks
  scan_timing_if timing ();

  osc_tick_gen #(
    .DIV (OSC_DIV)
  ) u_osc_tick_gen (
    .core_clk (core_clk),
    .rstSyncN (rstSyncN),
    .timing   (timing)
  );

  // State
  scan_state_t         state_reg;
  scan_state_t         state_next;
  logic [9:0]          tCnt_reg;
  logic [9:0]          tCnt_next;
  logic [5:0]          scanCfg_reg;
  logic                sleepSel_reg;
  logic                cfgWritten_reg;
  logic [KEY_BITS-1:0] pass1_reg;
  logic [KEY_BITS-1:0] pass2_reg;
  logic [KEY_BITS-1:0] keys_reg;
  logic                sleepAck_reg;

  // Register decode
  wire ctrlWr  = regWrStb && (regAddr == ADDR_CTRL);
  wire keysRd  = regRdStb && (regAddr == ADDR_KEYS);
  wire tick    = timing.oscTick;
  wire reqLive = (state_reg == ST_REQ);

  // Scan slot decode
  wire [2:0] curLine   = lineOf(tCnt_reg);
  wire [5:0] curOffset = slotOffset(tCnt_reg);
  wire       scanning  = (state_reg == ST_PASS1) || (state_reg == ST_PASS2);
  wire       sampleNow = scanning && tick && (curOffset == SAMPLE_AT_T[5:0]);
  wire [4:0] bitBase   = 5'(curLine) * 5'd5;
  wire       lineIdleHigh = scanCfg_reg[curLine];
  wire [4:0] senseMasked  = senseSync & {5{lineIdleHigh}};

  wire       pressSeen = |senseSync;
  wire       passEnd   = tick && (tCnt_reg == TWO_PASS_T - 10'd1);
  wire       pass1End  = tick && (tCnt_reg == SCAN_PASS_T - 10'd1);
  wire       delayEnd  = tick && (tCnt_reg == REQ_DELAY_T - 10'd1);
  wire       passMatch = (pass1_reg == pass2_reg);
  wire       anyKey    = |pass2_reg;

  // Scan outputs: standby level, or one pulse per configured-high line
  logic [KEY_LINES-1:0] scanDrive;
  assign scanDrive = scanning
                   ? (scanCfg_reg & (KEY_LINES'(1) << curLine))
                   : scanCfg_reg;

  // Oscillator runs once configured, unless idle in sleep mode; a press restarts it
  assign timing.oscRun = cfgWritten_reg
                       && (!sleepSel_reg || (state_reg != ST_IDLE) || pressSeen);

  always_comb begin
    state_next = state_reg;
    tCnt_next  = tCnt_reg;
    case (state_reg)
      ST_OFF: begin
        if (ctrlWr) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        tCnt_next = CNT_ZERO;
        if (pressSeen && tick) begin
          state_next = ST_PASS1;
        end
      end
      ST_PASS1: begin
        tCnt_next = tick ? tCnt_reg + 10'd1 : tCnt_reg;
        if (pass1End) begin
          state_next = ST_PASS2;
        end
      end
      ST_PASS2: begin
        tCnt_next = tick ? tCnt_reg + 10'd1 : tCnt_reg;
        if (passEnd) begin
          if (passMatch && anyKey) begin
            state_next = ST_DELAY;
          end else if (!passMatch && anyKey) begin
            state_next = ST_PASS1;
            tCnt_next  = CNT_ZERO;
          end else begin
            state_next = ST_IDLE;
          end
        end
      end
      ST_DELAY: begin
        tCnt_next = tick ? tCnt_reg + 10'd1 : tCnt_reg;
        if (delayEnd) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        tCnt_next = CNT_ZERO;
        if (keysRd) begin
          state_next = ST_PASS1;
        end
      end
      default: begin
        state_next = ST_OFF;
        tCnt_next  = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      state_reg <= ST_OFF;
      tCnt_reg  <= CNT_ZERO;
    end else begin
      state_reg <= state_next;
      tCnt_reg  <= tCnt_next;
    end
  end

  // Control register; reads of key data never touch it
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      scanCfg_reg    <= CFG_RESET;
      sleepSel_reg   <= SLEEP_RESET;
      cfgWritten_reg <= 1'b0;
    end else if (ctrlWr) begin
      scanCfg_reg    <= regWrData[KEY_LINES-1:0];
      sleepSel_reg   <= regWrData[CTRL_SLEEP_BIT];
      cfgWritten_reg <= 1'b1;
    end
  end

  // Per-pass capture; a press on several keys sets several bits
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pass1_reg <= KEYS_RESET;
      pass2_reg <= KEYS_RESET;
    end else if (sampleNow) begin
      if (state_reg == ST_PASS1) begin
        pass1_reg[bitBase +: SENSE_LINES] <= senseMasked;
      end else begin
        pass2_reg[bitBase +: SENSE_LINES] <= senseMasked;
      end
    end
  end

  // Key map only changes on an agreed pair of passes
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      keys_reg <= KEYS_RESET;
    end else if ((state_reg == ST_PASS2) && passEnd && passMatch && anyKey) begin
      keys_reg <= pass2_reg;
    end
  end

  // Sleep ack: mode at press, or a mode written while the request stands
  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sleepAck_reg <= SLEEP_RESET;
    end else if (reqLive && ctrlWr) begin
      sleepAck_reg <= regWrData[CTRL_SLEEP_BIT];
    end else if ((state_reg == ST_IDLE) && (state_next == ST_PASS1)) begin
      sleepAck_reg <= sleepSel_reg;
    end
  end

  // Request line; transfer select wins over a pending request
  logic pullLow_reg;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      pullLow_reg <= 1'b0;
      scanOutputs <= '0;
    end else begin
      pullLow_reg <= (state_next == ST_REQ) && !xferSync && cfgWritten_reg;
      scanOutputs <= cfgWritten_reg ? scanDrive : '0;
    end
  end

  assign dataOutOut = 1'b0;
  assign dataOutOeN = !pullLow_reg;

  // Read port, data one cycle after the strobe
  wire [31:0] ctrlWord = 32'({sleepSel_reg, scanCfg_reg});
  wire [31:0] keysWord = 32'({sleepAck_reg, keys_reg});
  wire [31:0] statWord = 32'({timing.oscRun, lineSync, cfgWritten_reg, reqLive});
  wire [31:0] rdSel    = (regAddr == ADDR_CTRL)   ? ctrlWord :
                         (regAddr == ADDR_KEYS)   ? keysWord :
                         (regAddr == ADDR_STATUS) ? statWord : 32'h00000000;

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      regRdData <= 32'h00000000;
    end else begin
      regRdData <= regRdStb ? rdSel : 32'h00000000;
    end
  end

endmodule : key_matrix_scanner

/* verification/key_matrix_scanner_chk.sv */
/*
  Port checker for the key matrix scanner.
  Assumes it is bound into key_matrix_scanner and sees only its ports.
*/
`timescale 1ns/100ps
module key_matrix_scanner_chk
  import key_scan_pkg::*;
#(
  parameter int OSC_DIV = OSC_DIV_DEFAULT
) (
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  input wire logic [ADDR_W-1:0]    regAddr,
  input wire logic [31:0]          regWrData,
  input wire logic                 regWrStb,
  input wire logic                 regRdStb,
  input wire logic [31:0]          regRdData,
  input wire logic [KEY_LINES-1:0] scanOutputs,
  input wire logic                 xferSelect,
  input wire logic                 dataOutOut,
  input wire logic                 dataOutOeN
);
  logic       cfgSeen_reg;
  logic [5:0] cfg_reg;
  wire        ctrlWr = regWrStb && regAddr == ADDR_CTRL;
  wire        keysRd = regRdStb && regAddr == ADDR_KEYS;
  wire        badAdr = regAddr != ADDR_CTRL && regAddr != ADDR_KEYS && regAddr != ADDR_STATUS;
  // Key bits of lines configured low
  wire [29:0] lowMask = {{5{~cfg_reg[5]}}, {5{~cfg_reg[4]}}, {5{~cfg_reg[3]}},
                         {5{~cfg_reg[2]}}, {5{~cfg_reg[1]}}, {5{~cfg_reg[0]}}};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgSeen_reg <= 1'b0;
      cfg_reg     <= 6'h00;
    end else if (ctrlWr) begin
      cfgSeen_reg <= 1'b1;
      cfg_reg     <= regWrData[5:0];
    end
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_cfg_first: assert property (!cfgSeen_reg |-> dataOutOeN && scanOutputs == 6'h00)
    else $error("request or scan active before config");
  chk_drive_low: assert property (dataOutOut == 1'b0)
    else $error("open drain output not low");
  chk_read_idle: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
    else $error("read data outside read cycle");
  chk_read_unmapped: assert property (regRdStb && badAdr |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  chk_keys_masked: assert property (keysRd |=> (regRdData[29:0] & lowMask) == 30'h0)
    else $error("key bit set on low line");
  chk_req_withdraw: assert property (keysRd && !dataOutOeN |=> dataOutOeN)
    else $error("request kept after key read");
  chk_xfer_release: assert property (xferSelect [*4] |-> dataOutOeN)
    else $error("request line driven during transfer");
  chk_scan_shape: assert property (cfgSeen_reg && $stable(cfg_reg) |->
      scanOutputs == cfg_reg || ($onehot0(scanOutputs) && (scanOutputs & ~cfg_reg) == 6'h00))
    else $error("scan outputs break level config");
endmodule : key_matrix_scanner_chk

bind key_matrix_scanner key_matrix_scanner_chk #(.OSC_DIV(OSC_DIV)) chk (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
  .scanOutputs(scanOutputs), .xferSelect(xferSelect), .dataOutOut(dataOutOut),
  .dataOutOeN(dataOutOeN)
);

/* verification/key_matrix_model.sv */
/*
  Key matrix and pulled-up request line outside the scanner.
  Assumes one switch per key, no sneak paths.
*/
`timescale 1ns/100ps
module key_matrix_model
  import key_scan_pkg::*;
(
  input  wire logic [KEY_BITS-1:0]    keyPressed,
  input  wire logic [KEY_LINES-1:0]   scanOutputs,
  output logic      [SENSE_LINES-1:0] senseInputs,
  input  wire logic                   dataOutOut,
  input  wire logic                   dataOutOeN,
  output logic                        dataOutLine
);
  always_comb begin
    senseInputs = 5'h00;
    for (int l = 0; l < KEY_LINES; l++)
      for (int s = 0; s < SENSE_LINES; s++)
        senseInputs[s] = senseInputs[s] | (scanOutputs[l] & keyPressed[l * 5 + s]);
  end
  // Pull-up wins whenever the scanner lets go
  assign dataOutLine = dataOutOeN ? 1'b1 : dataOutOut;
endmodule : key_matrix_model

/* verification/test_key_matrix_scanner.sv */
/*
  Self-checking bench: register tasks and key press sequences.
  Assumes key_matrix_model stands for the keys and the pull-up.
*/
`timescale 1ns/100ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module test_key_matrix_scanner
  import key_scan_pkg::*;
;
  localparam int DIV = 4;
  logic        core_clk, rst_n, regWrStb, regRdStb, xferSelect;
  logic [3:0]  regAddr;
  logic [31:0] regWrData, regRdData;
  logic [5:0]  scanOutputs;
  logic [4:0]  senseInputs;
  logic [29:0] keyPressed;
  logic        dataOutOut, dataOutOeN, dataOutLine;
  int          fails, comparisons, n;

  key_matrix_scanner #(.OSC_DIV(DIV)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .scanOutputs(scanOutputs), .senseInputs(senseInputs),
    .xferSelect(xferSelect), .dataOutIn(dataOutLine), .dataOutOut(dataOutOut),
    .dataOutOeN(dataOutOeN));
  key_matrix_model matrix (.keyPressed(keyPressed), .scanOutputs(scanOutputs),
    .senseInputs(senseInputs), .dataOutOut(dataOutOut), .dataOutOeN(dataOutOeN),
    .dataOutLine(dataOutLine));

  always #2.5 core_clk = ~core_clk;

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask : wrReg

  task automatic rdChk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge core_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 `CHECK(regRdData & m, e)
  endtask : rdChk

  // Settled level seen on falling edges; returns on a rising edge so stimulus follows it
  task automatic waitReq(input int lim);
    n = 0;
    while (dataOutOeN !== 1'b0 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask : waitReq

  // Tests need about 40k cycles; margin kept under the run limit
  initial begin
    #400000;
    fails++;
    summarize();
  end

  initial begin
    core_clk = 1'b0; rst_n = 1'b0; regAddr = 4'h0; regWrData = 32'h0; regWrStb = 1'b0;
    regRdStb = 1'b0; xferSelect = 1'b0; keyPressed = 30'h0; fails = 0; comparisons = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    keyPressed <= 30'h1000;
    waitReq(4000);
    `CHECK(dataOutOeN, 1'b1)
    rdChk(ADDR_KEYS, 32'hffffffff, 32'h0);
    keyPressed <= 30'h0;
    wrReg(4'hc, 32'h7f);
    rdChk(4'hc, 32'hffffffff, 32'h0);
    wrReg(ADDR_CTRL, 32'h3c);
    rdChk(ADDR_STATUS, 32'h2, 32'h2);
    `CHECK(scanOutputs, 6'h3c)
    keyPressed <= 30'h1;
    waitReq(4000);
    `CHECK(dataOutOeN, 1'b1)
    keyPressed <= 30'h20001000;
    waitReq(6000);
    `CHECK(n >= 800 * DIV && n <= 800 * DIV + 16, 1'b1)
    rdChk(ADDR_STATUS, 32'h1, 32'h1);
    rdChk(ADDR_KEYS, 32'h7fffffff, 32'h20001000);
    `CHECK($countones(keyPressed) < 3, 1'b1)
    waitReq(6000);
    `CHECK(n >= 800 * DIV - 4 && n <= 800 * DIV + 16, 1'b1)
    keyPressed <= 30'h4000;
    rdChk(ADDR_KEYS, 32'h7fffffff, 32'h20001000);
    waitReq(8000);
    `CHECK(dataOutOeN, 1'b0)
    xferSelect <= 1'b1;
    repeat (5) @(negedge core_clk);
    `CHECK(dataOutOeN, 1'b1)
    rdChk(ADDR_STATUS, 32'h1, 32'h1);
    xferSelect <= 1'b0;
    waitReq(10);
    `CHECK(dataOutOeN, 1'b0)
    rdChk(ADDR_KEYS, 32'h7fffffff, 32'h4000);
    keyPressed <= 30'h400;
    repeat (500 * DIV) @(posedge core_clk);
    keyPressed <= 30'h2000400;
    waitReq(8000);
    `CHECK(n > 1000 * DIV, 1'b1)
    rdChk(ADDR_KEYS, 32'h7fffffff, 32'h2000400);
    keyPressed <= 30'h0;
    repeat (4000) @(posedge core_clk);
    keyPressed <= 30'h400;
    repeat (300 * DIV) @(posedge core_clk);
    keyPressed <= 30'h0;
    waitReq(4000);
    `CHECK(dataOutOeN, 1'b1)
    wrReg(ADDR_CTRL, 32'h7f);
    repeat (50) @(posedge core_clk);
    keyPressed <= 30'h1;
    waitReq(8000);
    `CHECK(dataOutOeN, 1'b0)
    rdChk(ADDR_KEYS, 32'h7fffffff, 32'h40000001);
    rdChk(ADDR_CTRL, 32'h7f, 32'h7f);
    waitReq(8000);
    `CHECK(dataOutOeN, 1'b0)
    wrReg(ADDR_CTRL, 32'h3f);
    rdChk(ADDR_KEYS, 32'h40000000, 32'h0);
    keyPressed <= 30'h0;
    repeat (100) @(posedge core_clk);
    summarize();
  end
endmodule : test_key_matrix_scanner
